// *** core/bit_fifo.sv ***
// synchronous fifo with registered full and empty flags
`timescale 1ns/1ns
module bit_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   input wire logic clk_i, // master clock
   input wire logic rst_i, // synchronous reset
   fifo_if.fifo f // push and pop sides
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic ready_r;
   logic valid_r;
   logic push;
   logic pop;

   // handshake qualifiers
   assign push = f.push_valid && ready_r;
   assign pop = f.pop_ready && valid_r;
   assign count_nxt = count_r + CW'(push) - CW'(pop);
   assign f.push_ready = ready_r;
   assign f.pop_valid = valid_r;
   assign f.pop_data = mem[rd_ptr_r];

   // storage, written only when space is free
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_r] <= f.push_data;
      end
   end

   // pointers, occupancy and flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         ready_r <= 1'b1;
         valid_r <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         count_r <= count_nxt;
         ready_r <= count_nxt != CW'(DEPTH);
         valid_r <= count_nxt != '0;
      end
   end
endmodule

// *** core/fifo_if.sv ***
// handshake bundle between the write path and its bit buffer
`timescale 1ns/1ns
interface fifo_if #(parameter int W = 1);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;
   modport fifo (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data);
   modport user (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data);
endinterface

// *** core/mfm_defines.svh ***
// named constants for the write precompensation encoder
`ifndef MFM_DEFINES_SVH
`define MFM_DEFINES_SVH
// ---------------------------------------------
// clocking
// ---------------------------------------------
`define MASTER_HZ 10000000
`define CLK_NS 100
`define STAGE_NS 15
`define STAGE_CYC (((`STAGE_NS + `CLK_NS - 1) / `CLK_NS) < 1 ? 1 : \
   ((`STAGE_NS + `CLK_NS - 1) / `CLK_NS))
`define DLY_LEN (2 * `STAGE_CYC)
// ---------------------------------------------
// shift register taps
// ---------------------------------------------
`define TAPS 5
`define TAP_NEXT2 0
`define TAP_NEXT1 1
`define TAP_CUR 2
`define TAP_PRIOR1 3
`define TAP_PRIOR2 4
// ---------------------------------------------
// buffering, filters and timers
// ---------------------------------------------
`define FIFO_DEPTH 16
`define TZ_STABLE 8
`define TZ_W 4
`define SILENCE_MS 10
`define SECTOR_US 2
`define SECTOR_CYC (`SECTOR_US * (`MASTER_HZ / 1000000))
`define SECT_W 5
`define SIL_W 17
`define HEADS 4
`define HEAD_RST 4'h1
`endif

// *** core/mfm_pkg.sv ***
// types shared by the write encoder design
`include "mfm_defines.svh"
package mfm_pkg;
   typedef logic [`HEADS-1:0] head_sel_t;
   typedef enum logic [1:0] {
      PC_EARLY = 2'b00,
      PC_NOMINAL = 2'b01,
      PC_LATE = 2'b10
   } precomp_t;
   typedef enum logic [1:0] {
      SD_LISTEN = 2'b00,
      SD_FIRE = 2'b01,
      SD_HOLD = 2'b10
   } sector_state_t;
endpackage

// *** core/mfm_write_precomp_encoder.sv ***
// mfm write encoder with precompensation, head select and sector watch
`timescale 1ns/1ns
`include "mfm_defines.svh"
// How it works
// - bit clock is master clock halved
// - master clock times precomp output stage
// - write data shifts through stages per bit
// - five taps: two prior, current, two next
// - encoder makes mfm pulses from neighbours
// - each pulse gets early, nominal or late
// - early undelayed, nominal one, late two stages
// - no precomp means nominal path always
// - at most one select active at once
// - pulse leading edge toggles current direction
// - clamp low holds direction flop reset
// - zero strings still give bit rate transitions
// - gate high kills all write current
// - supply fail inhibits any write
// - two bit code picks one of four
// - exactly one head, shared read and write
// - bit clock syncs read oscillator while writing
// - track zero input is noise filtered
// - read silence 10 ms gives sector pulse
// - recovered data and clock returned
module mfm_write_precomp_encoder #(
   parameter int SILENCE_CYCLES = `SILENCE_MS * (`MASTER_HZ / 1000)
) (
   input wire logic clk_i, // 10 MHz master clock
   input wire logic rst_i, // synchronous reset, high
   input wire logic serial_write_input_i, // nrz write bit
   input wire logic serial_valid_i, // write bit offered
   output logic serial_ready_o, // buffer has room
   input wire logic write_gate_n_i, // low to write
   input wire logic supply_good_i, // power good
   input wire logic inner_track_low_current_i, // inner track request
   input wire logic sector_clamp_n_i, // low clamps direction flop
   input wire logic head_code_low_i, // head code bit 0
   input wire logic head_code_high_i, // head code bit 1
   input wire logic track_zero_i, // raw track zero sensor
   input wire logic read_pulse_i, // digitized read pulse
   input wire logic read_data_i, // recovered nrz data
   input wire logic read_clock_i, // recovered clock
   output logic bit_shift_clock_o, // 5 MHz bit clock
   output logic vco_sync_o, // oscillator sync while writing
   output logic early_select_o, // early path active
   output logic nominal_select_o, // on-time path active
   output logic late_select_o, // late path active
   output logic final_write_pulse_o, // compensated write pulse
   output logic head_current_dir_o, // write current direction
   output logic write_current_en_o, // write current on
   output logic reduced_current_o, // reduced write current
   output mfm_pkg::head_sel_t head_select_o, // one-hot head
   output logic track_zero_o, // filtered track zero
   output logic sector_pulse_o, // sector mark found
   output logic read_data_o, // nrz data to controller
   output logic read_clock_o // clock to controller
);
   import mfm_pkg::*;

   // ---------------------------------------------
   // declarations
   // ---------------------------------------------
   fifo_if #(.W(1)) buf_if ();
   logic phase_r;
   logic bit_en;
   logic write_active;
   logic [`TAPS-1:0] taps_r;
   logic want_clock;
   logic want_data;
   logic want_pulse;
   precomp_t sel_nxt;
   logic raw_r;
   precomp_t raw_sel_r;
   logic [`DLY_LEN-1:0] pulse_dly_r;
   logic [`DLY_LEN-1:0] nom_dly_r;
   logic [`DLY_LEN-1:0] late_dly_r;
   logic final_nxt;
   logic [1:0] head_code;
   head_sel_t head_hot;
   logic [`TZ_W-1:0] tz_cnt_r;
   logic tz_sample_r;
   sector_state_t sd_state_r;
   logic [`SIL_W-1:0] silence_cnt_r;
   logic [`SECT_W-1:0] sect_cnt_r;

   // ---------------------------------------------
   // bit clock divider
   // ---------------------------------------------
   // master clock halved into a one-cycle bit enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_r <= 1'b0;
      end else begin
         phase_r <= ~phase_r;
      end
   end
   assign bit_en = ~phase_r;
   assign write_active = ~write_gate_n_i & supply_good_i;

   // visible bit clock and oscillator sync
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_shift_clock_o <= 1'b0;
         vco_sync_o <= 1'b0;
      end else begin
         bit_shift_clock_o <= ~phase_r;
         vco_sync_o <= ~phase_r & write_active;
      end
   end

   // ---------------------------------------------
   // write bit buffer
   // ---------------------------------------------
   // buffer drains only while writing, so the source can be stalled
   assign buf_if.push_valid = serial_valid_i;
   assign buf_if.push_data = serial_write_input_i;
   assign buf_if.pop_ready = bit_en & write_active;
   assign serial_ready_o = buf_if.push_ready;

   bit_fifo #(
      .WIDTH(1),
      .DEPTH(`FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .f(buf_if)
   );

   // ---------------------------------------------
   // neighbourhood shift register
   // ---------------------------------------------
   // newest bit enters the next-two tap; an empty buffer shifts zeros
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         taps_r <= '0;
      end else if (bit_en && write_active) begin
         taps_r <= {taps_r[`TAPS-2:0], buf_if.pop_valid & buf_if.pop_data[0]};
      end
   end

   // ---------------------------------------------
   // mfm encoder and precomp decision
   // ---------------------------------------------
   // boundary pulse on phase 1, data pulse on phase 0 of a cell
   always_comb begin
      want_data = taps_r[`TAP_CUR];
      want_clock = ~taps_r[`TAP_CUR] & ~taps_r[`TAP_PRIOR1];
      want_pulse = phase_r ? want_clock : want_data;
      sel_nxt = PC_NOMINAL;
      if (inner_track_low_current_i) begin
         if (phase_r) begin
            if (taps_r[`TAP_PRIOR2] && !taps_r[`TAP_NEXT1]) begin
               sel_nxt = PC_LATE;
            end else if (!taps_r[`TAP_PRIOR2] && taps_r[`TAP_NEXT1]) begin
               sel_nxt = PC_EARLY;
            end
         end else begin
            if (taps_r[`TAP_PRIOR1] && !taps_r[`TAP_NEXT1]) begin
               sel_nxt = PC_LATE;
            end else if (!taps_r[`TAP_PRIOR1] && taps_r[`TAP_NEXT1]) begin
               sel_nxt = PC_EARLY;
            end
         end
      end
   end

   // uncompensated pulse with its chosen path
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         raw_r <= 1'b0;
         raw_sel_r <= PC_NOMINAL;
      end else begin
         raw_r <= want_pulse & write_active;
         raw_sel_r <= sel_nxt;
      end
   end

   // ---------------------------------------------
   // precompensation delay stages
   // ---------------------------------------------
   // each stage is one master clock; selects travel with their pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_dly_r <= '0;
         nom_dly_r <= '0;
         late_dly_r <= '0;
      end else begin
         pulse_dly_r <= {pulse_dly_r[`DLY_LEN-2:0], raw_r};
         nom_dly_r <= {nom_dly_r[`DLY_LEN-2:0], raw_r && raw_sel_r == PC_NOMINAL};
         late_dly_r <= {late_dly_r[`DLY_LEN-2:0], raw_r && raw_sel_r == PC_LATE};
      end
   end

   // one path gates its tap onto the write-pulse line
   assign final_nxt = write_active &
      ((raw_r && raw_sel_r == PC_EARLY) |
       (pulse_dly_r[`STAGE_CYC-1] & nom_dly_r[`STAGE_CYC-1]) |
       (pulse_dly_r[`DLY_LEN-1] & late_dly_r[`DLY_LEN-1]));

   // final pulse and the path that produced it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         final_write_pulse_o <= 1'b0;
         early_select_o <= 1'b0;
         nominal_select_o <= 1'b0;
         late_select_o <= 1'b0;
      end else begin
         final_write_pulse_o <= final_nxt;
         early_select_o <= final_nxt & raw_r & (raw_sel_r == PC_EARLY);
         nominal_select_o <= final_nxt & nom_dly_r[`STAGE_CYC-1] & ~(raw_r &
            (raw_sel_r == PC_EARLY));
         late_select_o <= final_nxt & late_dly_r[`DLY_LEN-1] & ~(raw_r &
            (raw_sel_r == PC_EARLY)) & ~nom_dly_r[`STAGE_CYC-1];
      end
   end

   // ---------------------------------------------
   // write current control
   // ---------------------------------------------
   // leading edge toggles direction; the clamp wins over a pulse
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         head_current_dir_o <= 1'b0;
      end else if (!sector_clamp_n_i) begin
         head_current_dir_o <= 1'b0;
      end else if (final_nxt && !final_write_pulse_o) begin
         head_current_dir_o <= ~head_current_dir_o;
      end
   end

   // current enable and reduced-current level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         write_current_en_o <= 1'b0;
         reduced_current_o <= 1'b0;
      end else begin
         write_current_en_o <= write_active;
         reduced_current_o <= write_active & inner_track_low_current_i;
      end
   end

   // ---------------------------------------------
   // head selection
   // ---------------------------------------------
   // one-hot decode, same head for reading and writing
   assign head_code = {head_code_high_i, head_code_low_i};
   generate
      for (genvar h = 0; h < `HEADS; h++) begin : g_head
         assign head_hot[h] = head_code == 2'(h);
      end
   endgenerate

   // one register for the whole select, so no bit has two writers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         head_select_o <= `HEAD_RST;
      end else begin
         head_select_o <= head_hot;
      end
   end

   // ---------------------------------------------
   // track zero filter
   // ---------------------------------------------
   // output latches only after a run of equal samples
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tz_sample_r <= 1'b0;
         tz_cnt_r <= '0;
         track_zero_o <= 1'b0;
      end else begin
         tz_sample_r <= track_zero_i;
         if (track_zero_i != tz_sample_r) begin
            tz_cnt_r <= '0;
         end else if (tz_cnt_r != `TZ_W'(`TZ_STABLE - 1)) begin
            tz_cnt_r <= tz_cnt_r + 1'b1;
         end else begin
            track_zero_o <= tz_sample_r;
         end
      end
   end

   // ---------------------------------------------
   // read side
   // ---------------------------------------------
   // recovered data and clock returned to the controller
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         read_data_o <= 1'b0;
         read_clock_o <= 1'b0;
      end else begin
         read_data_o <= read_data_i;
         read_clock_o <= read_clock_i;
      end
   end

   // sector mark watch, no new pulse starts while writing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sd_state_r <= SD_LISTEN;
         silence_cnt_r <= '0;
         sect_cnt_r <= '0;
         sector_pulse_o <= 1'b0;
      end else begin
         unique case (sd_state_r)
            SD_LISTEN: begin
               sector_pulse_o <= 1'b0;
               if (read_pulse_i || write_active) begin
                  silence_cnt_r <= '0;
               end else if (silence_cnt_r == `SIL_W'(SILENCE_CYCLES - 1)) begin
                  silence_cnt_r <= '0;
                  sect_cnt_r <= '0;
                  sector_pulse_o <= 1'b1;
                  sd_state_r <= SD_FIRE;
               end else begin
                  silence_cnt_r <= silence_cnt_r + 1'b1;
               end
            end
            SD_FIRE: begin
               if (sect_cnt_r == `SECT_W'(`SECTOR_CYC - 1)) begin
                  sector_pulse_o <= 1'b0;
                  sd_state_r <= SD_HOLD;
               end else begin
                  sect_cnt_r <= sect_cnt_r + 1'b1;
               end
            end
            SD_HOLD: begin
               if (read_pulse_i || write_active) begin
                  sd_state_r <= SD_LISTEN;
               end
            end
            default: begin
               sector_pulse_o <= 1'b0;
               sd_state_r <= SD_LISTEN;
            end
         endcase
      end
   end

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_bit_clock_half: assert property (
      bit_en |=> !bit_en ##1 bit_en) else $error("bit enable not half rate");

   a_shift_chain: assert property (
      bit_en && write_active |=> taps_r[`TAPS-1:1] == $past(taps_r[`TAPS-2:0]))
      else $error("shift stages did not pass values");

   a_taps_hold: assert property (
      !bit_en |=> $stable(taps_r)) else $error("taps moved off bit clock");

   a_mfm_data: assert property (
      bit_en && write_active && taps_r[`TAP_CUR] |=> raw_r)
      else $error("one bit gave no mid cell pulse");

   a_mfm_clock: assert property (
      !bit_en && write_active && !taps_r[`TAP_CUR] && !taps_r[`TAP_PRIOR1]
      |=> raw_r) else $error("zero pair gave no boundary pulse");

   a_no_double: assert property (
      bit_en && !taps_r[`TAP_CUR] |=> !raw_r) else $error("zero gave data pulse");

   a_plain_nominal: assert property (
      !inner_track_low_current_i |=> raw_sel_r == PC_NOMINAL)
      else $error("precomp without inner track request");

   a_early_path: assert property (
      raw_r && raw_sel_r == PC_EARLY && write_active |=> final_write_pulse_o)
      else $error("early pulse not undelayed");

   a_nominal_path: assert property (
      raw_r && raw_sel_r == PC_NOMINAL ##1 write_active |=> final_write_pulse_o)
      else $error("nominal pulse not one stage late");

   a_late_path: assert property (
      raw_r && raw_sel_r == PC_LATE ##2 write_active |=> final_write_pulse_o)
      else $error("late pulse not two stages late");

   a_select_excl: assert property (
      $onehot0({early_select_o, nominal_select_o, late_select_o}))
      else $error("more than one precomp path");

   a_dir_toggle: assert property (
      $rose(final_write_pulse_o) && $past(sector_clamp_n_i)
      |-> head_current_dir_o != $past(head_current_dir_o))
      else $error("pulse edge did not toggle direction");

   a_clamp_hold: assert property (
      !sector_clamp_n_i [*2] |=> !head_current_dir_o && $stable(head_current_dir_o))
      else $error("clamp did not hold direction");

   a_gate_kill: assert property (
      write_gate_n_i |=> !write_current_en_o && !final_write_pulse_o)
      else $error("write current with gate high");

   a_supply_kill: assert property (
      !supply_good_i |=> !write_current_en_o && !reduced_current_o)
      else $error("write with supply fault");

   a_head_decode: assert property (
      ##1 head_select_o == (4'h1 << $past(head_code)))
      else $error("wrong head selected");

   a_head_single: assert property (
      $onehot(head_select_o)) else $error("not exactly one head");

   a_vco_sync: assert property (
      write_active |=> vco_sync_o == bit_shift_clock_o)
      else $error("oscillator sync lost while writing");

   a_tz_latch: assert property (
      $changed(track_zero_o) |-> $past(tz_cnt_r) == `TZ_W'(`TZ_STABLE - 1))
      else $error("track zero changed before filter ran");

   a_sector_width: assert property (
      $rose(sector_pulse_o) |-> sector_pulse_o [*8])
      else $error("sector pulse too short");

   a_read_return: assert property (
      ##1 read_data_o == $past(read_data_i) && read_clock_o == $past(read_clock_i))
      else $error("read data not returned");

   c_precomp_late: cover property (late_select_o);
   c_precomp_early: cover property (early_select_o);
   c_sector_mark: cover property ($rose(sector_pulse_o));
   c_fifo_full: cover property (!serial_ready_o);
endmodule

// *** verif/test_mfm_write_precomp_encoder.sv ***
// self-checking bench for the mfm write precompensation encoder
`timescale 1ns/1ns
module test_mfm_write_precomp_encoder;
   import mfm_pkg::*;
   logic clk_i, rst_i, wgn, sgood, inner, clamp_n, hc0, hc1, tz, rp, rd, rc, go, pclamp, pdir, pfwp;
   logic rdy, sdata, svalid, bclk, vsync, early_select, nom, late_select, fwp, dir, wcen, redc, tzo, secp, rdo, rco;
   head_sel_t hsel;
   logic [15:0] word;
   int bad_count = 0, n_checks = 0, cyc_count = 0, n_pulse = 0, n_early = 0, n_late = 0, n;
   int n_nom = 0;
   // ---------------------------------
   // design, controller model, clock
   // ---------------------------------
   mfm_write_precomp_encoder #(.SILENCE_CYCLES(50)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .serial_write_input_i(sdata), .serial_valid_i(svalid), .serial_ready_o(rdy),
      .write_gate_n_i(wgn), .supply_good_i(sgood), .inner_track_low_current_i(inner),
      .sector_clamp_n_i(clamp_n), .head_code_low_i(hc0), .head_code_high_i(hc1),
      .track_zero_i(tz), .read_pulse_i(rp), .read_data_i(rd), .read_clock_i(rc),
      .bit_shift_clock_o(bclk), .vco_sync_o(vsync), .early_select_o(early_select),
      .nominal_select_o(nom), .late_select_o(late_select), .final_write_pulse_o(fwp),
      .head_current_dir_o(dir), .write_current_en_o(wcen), .reduced_current_o(redc),
      .head_select_o(hsel), .track_zero_o(tzo), .sector_pulse_o(secp),
      .read_data_o(rdo), .read_clock_o(rco));
   write_controller_model ctl (.clk_i(clk_i), .rst_i(rst_i), .word_i(word), .go_i(go),
      .ready_i(rdy), .data_o(sdata), .valid_o(svalid));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
      #10;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // tally pulses, watch direction and select exclusivity once outputs settle
   always @(posedge clk_i) begin
      #20;
      if (fwp === 1'b1) begin
         n_pulse++;
         check((early_select & nom) | (early_select & late_select) | (nom & late_select), 1'b0);
      end
      // direction flips only on a rising pulse edge seen with the clamp released
      if (pclamp === 1'b1) check(dir, (fwp === 1'b1 && pfwp === 1'b0) ? !pdir : pdir);
      n_early += (early_select === 1'b1);
      n_late += (late_select === 1'b1);
      n_nom += (nom === 1'b1);
      pdir = dir;
      pclamp = clamp_n;
      pfwp = fwp;
   end
   // cut a hang short
   always @(posedge clk_i) begin
      cyc_count++;
      if (cyc_count == 5000) begin
         bad_count++;
         give_verdict();
      end
   end
   // ---------------------------------
   // scenarios
   // ---------------------------------
   task automatic t_heads();
      check({hsel, rdy}, 5'h03);
      for (int i = 0; i < 4; i++) begin
         {hc1, hc0} = 2'(i);
         cyc(2);
         check(hsel, 4'h1 << i);
      end
      {hc1, hc0} = 2'h0;
   endtask
   task automatic t_gate();
      wgn = 1'b0;
      inner = 1'b1;
      cyc(2);
      check({wcen, redc}, 2'h3);
      sgood = 1'b0;
      cyc(4);
      check(wcen, 1'b0);
      n_pulse = 0;
      cyc(8);
      check(n_pulse, 0);
      {sgood, wgn} = 2'h3;
      cyc(2);
      check({wcen, redc}, 2'h0);
   endtask
   task automatic t_stream(input logic [15:0] w, input logic trk, input int len, input int np);
      logic b;
      {inner, wgn} = {trk, 1'b0};
      cyc(10);
      word = w;
      go = (w != 16'h0000);
      {n_pulse, n_early, n_late, n_nom} = {32'h0, 32'h0, 32'h0, 32'h0};
      b = bclk;
      cyc(1);
      go = 1'b0;
      check(bclk, !b);
      cyc(len - 1);
      check(n_pulse, np);
      check(vsync, bclk);
   endtask
   task automatic t_fifo();
      wgn = 1'b1;
      cyc(4);
      word = 16'hA5C3;
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      cyc(24);
      check({rdy, svalid}, 2'h0);
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      cyc(4);
      check({rdy, svalid}, 2'h1);
      wgn = 1'b0;
      for (n = 0; svalid === 1'b1 && n < 100; n++) cyc(1);
      cyc(40);
      check({rdy, svalid}, 2'h2);
   endtask
   task automatic t_clamp();
      clamp_n = 1'b0;
      cyc(2);
      repeat (8) begin
         check(dir, 1'b0);
         cyc(1);
      end
      clamp_n = 1'b1;
      cyc(4);
   endtask
   task automatic t_sector();
      {wgn, rp} = 2'h3;
      cyc(1);
      rp = 1'b0;
      for (n = 0; secp !== 1'b1 && n < 100; n++) cyc(1);
      check(n, 50);
      for (n = 0; secp === 1'b1 && n < 40; n++) cyc(1);
      check(n, 20);
   endtask
   task automatic t_misc();
      tz = 1'b1;
      cyc(3);
      tz = 1'b0;
      cyc(12);
      check(tzo, 1'b0);
      tz = 1'b1;
      cyc(14);
      check(tzo, 1'b1);
      {rd, rc} = 2'h3;
      cyc(1);
      check({rdo, rco}, 2'h3);
      rd = 1'b0;
      cyc(1);
      check({rdo, rco}, 2'h1);
   endtask
   // main sequence
   initial begin
      {rst_i, wgn, sgood, clamp_n} = 4'hF;
      {inner, hc0, hc1, tz, rp, rd, rc, go} = 8'h00;
      word = 16'h0000;
      cyc(10);
      rst_i = 1'b0;
      cyc(1);
      t_heads();
      t_gate();
      t_stream(16'h0000, 1'b0, 40, 20);
      t_stream(16'h6666, 1'b1, 60, 26);
      check({n_early != 0, n_late != 0}, 2'h3);
      check(n_nom, 16);
      t_stream(16'h6666, 1'b0, 60, 26);
      check(n_early + n_late, 0);
      check(n_nom, 26);
      t_fifo();
      t_clamp();
      t_sector();
      t_misc();
      give_verdict();
   end
endmodule

// *** verif/write_controller_model.sv ***
// controller-side model that serialises write bits into the encoder
`timescale 1ns/1ns
module write_controller_model (
   input wire logic clk_i, // master clock
   input wire logic rst_i, // synchronous reset
   input wire logic [15:0] word_i, // bits to send, msb first
   input wire logic go_i, // start one word
   input wire logic ready_i, // encoder buffer has room
   output logic data_o, // nrz bit
   output logic valid_o // bit offered
);
   logic [4:0] left_r;
   logic [15:0] word_r;
   // offer each bit and hold it until the buffer takes it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         left_r <= 5'h00;
         word_r <= 16'h0000;
      end else if (go_i && left_r == 5'h00) begin
         left_r <= 5'h10;
         word_r <= word_i;
      end else if (valid_o && ready_i) begin
         left_r <= left_r - 5'h01;
         word_r <= {word_r[14:0], 1'b0};
      end
   end
   // high for a one, low for a zero; inverse of the head bit when idle
   assign valid_o = (left_r != 5'h00);
   assign data_o = valid_o ? word_r[15] : ~word_r[15];
endmodule
